// ==== dpmf_pkg.sv ====
// Shared constants and carrier types for the two-port mailbox flag block.
// Assumes one system clock shared by both port front ends.
package dpmf_pkg;

    // Address and data geometry
    localparam int ADDR_W = 16;                // Word address width
    localparam int LANES  = 4;                 // Byte lanes per word
    localparam int LANE_W = 9;                 // Bits per byte lane
    localparam int DATA_W = LANES * LANE_W;    // Word width

    // Mailbox word locations
    localparam logic [ADDR_W-1:0] MBOX_RIGHT_ADDR = 16'hFFFF; // Owned by right port
    localparam logic [ADDR_W-1:0] MBOX_LEFT_ADDR  = 16'hFFFE; // Owned by left port

    // Port indices
    localparam int PORT_LEFT  = 0;
    localparam int PORT_RIGHT = 1;

    // Values after reset
    localparam logic [ADDR_W-1:0] CNT_RESET_VAL  = 16'h0000; // Burst counter
    localparam logic [ADDR_W-1:0] MASK_RESET_VAL = 16'hFFFF; // Fully unmasked
    localparam logic [DATA_W-1:0] DATA_RESET_VAL = 36'h000000000;
    localparam logic              FLAG_IDLE      = 1'b1;     // Active-low flags idle high

    // One port access as seen at the clock edge
    typedef struct packed {
        logic                  chip_sel_low;       // Active low select
        logic                  chip_sel_high;      // Active high select
        logic                  rnw;                // 1 read, 0 write
        logic [LANES-1:0]      byte_lane_select_n; // Active low lanes
        logic [ADDR_W-1:0]     addr;               // Word address
        logic [DATA_W-1:0]     wdata;              // Write data
    } dpmf_port_s;

    // Burst counter and mask controls, all active low except counter_sel
    typedef struct packed {
        logic counter_sel;   // 1 counter ops, 0 mask ops
        logic op_reset_n;    // Reset counter or mask
        logic load_n;        // Load from address
        logic count_en_n;    // Increment enable
    } dpmf_cnt_ctl_s;

endpackage : dpmf_pkg

// ==== dpmf_burst_counter.sv ====
// Per-port burst address counter with mask register and wrap flag.
// Assumes controls are synchronous to sys_clk; the global reset is not.
`timescale 1ns/1ps
module dpmf_burst_counter #(
    parameter int ADDR_W = dpmf_pkg::ADDR_W
) (
    // Clock, resets, enable
    input  wire logic                  sys_clk,
    input  wire logic                  rst_n,
    input  wire logic                  global_async_reset_n,
    input  wire logic                  clk_en,
    // Controls
    input  wire dpmf_pkg::dpmf_cnt_ctl_s ctl,
    input  wire logic [ADDR_W-1:0]     addr,
    // State out
    output logic [ADDR_W-1:0]          count,
    output logic [ADDR_W-1:0]          mask,
    output logic                       counter_wrap_flag_n
);

    logic [ADDR_W-1:0] next_count;   // Incremented value
    logic              do_inc;       // Increment this edge
    logic              do_load;      // Counter load this edge
    logic              do_crst;      // Counter reset this edge

    // Decode of the control table
    assign do_crst = ctl.counter_sel && !ctl.op_reset_n;
    assign do_load = ctl.counter_sel && ctl.op_reset_n && !ctl.load_n && !ctl.count_en_n;
    assign do_inc  = ctl.counter_sel && ctl.op_reset_n && ctl.load_n && !ctl.count_en_n;

    // Masked bits forced to one so the carry skips them, then held
    always_comb begin
        next_count = (((count | ~mask) + 1'b1) & mask) | (count & ~mask);
    end

    // Counter register
    always_ff @(posedge sys_clk or negedge global_async_reset_n) begin
        if (!global_async_reset_n) begin
            count <= dpmf_pkg::CNT_RESET_VAL;
        end else if (!rst_n) begin
            count <= dpmf_pkg::CNT_RESET_VAL;
        end else if (clk_en) begin
            if (do_crst) begin
                count <= count & ~mask;         // Unmasked bits to zero
            end else if (do_load) begin
                count <= addr;
            end else if (do_inc) begin
                count <= next_count;
            end
        end
    end

    // Mask register
    always_ff @(posedge sys_clk or negedge global_async_reset_n) begin
        if (!global_async_reset_n) begin
            mask <= dpmf_pkg::MASK_RESET_VAL;
        end else if (!rst_n) begin
            mask <= dpmf_pkg::MASK_RESET_VAL;
        end else if (clk_en && !ctl.counter_sel) begin
            if (!ctl.op_reset_n) begin
                mask <= dpmf_pkg::MASK_RESET_VAL;
            end else if (!ctl.load_n && !ctl.count_en_n) begin
                mask <= addr;
            end
        end
    end

    // Wrap flag: low once the unmasked field reaches all ones
    always_ff @(posedge sys_clk or negedge global_async_reset_n) begin
        if (!global_async_reset_n) begin
            counter_wrap_flag_n <= dpmf_pkg::FLAG_IDLE;
        end else if (!rst_n) begin
            counter_wrap_flag_n <= dpmf_pkg::FLAG_IDLE;
        end else if (clk_en) begin
            if (do_inc && ((next_count & mask) == mask)) begin
                counter_wrap_flag_n <= 1'b0;
            end else if (do_load || do_crst) begin
                counter_wrap_flag_n <= dpmf_pkg::FLAG_IDLE;
            end
        end
    end

endmodule : dpmf_burst_counter

// ==== dpmf_mailbox_top.sv ====
// Mailbox flags, mailbox words and global reset for a two-port memory.
// Assumes both ports are sampled on sys_clk; global reset may be asynchronous.
// How it works
// - Top word right mailbox, next left.
// - Opposite-port mailbox write lowers owner flag.
// - Setting needs an active byte lane.
// - Owner reading own mailbox raises flag.
// - Clearing needs an active byte lane.
// - Flag sets on writer's clock edge.
// - Flag clears on reader's clock edge.
// - Reading other mailbox leaves its flag.
// - Writing own mailbox sets no flag.
// - Global reset async, hits both ports.
// - Reset zeroes counters, masks all ones.
// - Reset idles mailbox and wrap flags high.
// - Wrap flag low at unmasked all ones.
// - Byte lane selects gate each byte.
`timescale 1ns/1ps
module dpmf_mailbox_top #(
    parameter int ADDR_W = dpmf_pkg::ADDR_W,
    parameter int LANES  = dpmf_pkg::LANES,
    parameter int LANE_W = dpmf_pkg::LANE_W
) (
    // Clock, resets, enable
    input  wire logic                    sys_clk,
    input  wire logic                    rst_n,
    input  wire logic                    global_async_reset_n,
    input  wire logic                    clk_en,
    // Port accesses
    input  wire dpmf_pkg::dpmf_port_s    left_req,
    input  wire dpmf_pkg::dpmf_port_s    right_req,
    // Counter controls
    input  wire dpmf_pkg::dpmf_cnt_ctl_s left_cnt_ctl,
    input  wire dpmf_pkg::dpmf_cnt_ctl_s right_cnt_ctl,
    // Mailbox read data
    output logic [LANES*LANE_W-1:0]      left_rdata,
    output logic [LANES*LANE_W-1:0]      right_rdata,
    output logic                         left_rvalid,
    output logic                         right_rvalid,
    // Flags, active low
    output logic                         left_mailbox_flag_n,
    output logic                         right_mailbox_flag_n,
    output logic                         left_counter_wrap_flag_n,
    output logic                         right_counter_wrap_flag_n,
    // Counter state
    output logic [ADDR_W-1:0]            left_count,
    output logic [ADDR_W-1:0]            right_count,
    output logic [ADDR_W-1:0]            left_mask,
    output logic [ADDR_W-1:0]            right_mask
);

    localparam int DATA_W = LANES * LANE_W;

    dpmf_pkg::dpmf_port_s    req     [2];   // Indexed by port
    dpmf_pkg::dpmf_cnt_ctl_s cnt_ctl [2];   // Indexed by port
    logic [ADDR_W-1:0]       own_addr[2];   // Mailbox owned by each port
    logic [1:0]              sel;           // Port selected
    logic [1:0]              any_lane;      // At least one lane active
    logic [1:0]              wr_mbox;       // Qualified write to port p's mailbox
    logic [1:0]              rd_own;        // Owner read of its mailbox
    logic [1:0]              rd_any;        // Read of either mailbox word
    logic [1:0]              flag_n;        // Mailbox flags
    logic [DATA_W-1:0]       mbox_word[2];  // Stored mailbox words
    logic [DATA_W-1:0]       rdata   [2];
    logic [1:0]              rvalid;
    logic [ADDR_W-1:0]       count   [2];
    logic [ADDR_W-1:0]       mask    [2];
    logic [1:0]              wrap_n;
    logic [1:0]              inc_now;       // Counter increment taken this edge

    // Gather the two ports into arrays
    assign req[dpmf_pkg::PORT_LEFT]       = left_req;
    assign req[dpmf_pkg::PORT_RIGHT]      = right_req;
    assign cnt_ctl[dpmf_pkg::PORT_LEFT]   = left_cnt_ctl;
    assign cnt_ctl[dpmf_pkg::PORT_RIGHT]  = right_cnt_ctl;
    assign own_addr[dpmf_pkg::PORT_LEFT]  = dpmf_pkg::MBOX_LEFT_ADDR;
    assign own_addr[dpmf_pkg::PORT_RIGHT] = dpmf_pkg::MBOX_RIGHT_ADDR;

    // Per-port decode and state
    for (genvar p = 0; p < 2; p++) begin : g_port
        localparam int Q = 1 - p;   // Opposite port

        // Chip selected only when low select low and high select high
        assign sel[p]      = !req[p].chip_sel_low && req[p].chip_sel_high;
        assign any_lane[p] = ~&req[p].byte_lane_select_n;
        // Only the opposite port's write counts; own writes set nothing
        assign wr_mbox[p]  = sel[Q] && !req[Q].rnw && any_lane[Q]
                             && (req[Q].addr == own_addr[p]);
        // Only the owner's read clears; the other port's read is ignored
        assign rd_own[p]   = sel[p] && req[p].rnw && any_lane[p]
                             && (req[p].addr == own_addr[p]);
        assign rd_any[p]   = sel[p] && req[p].rnw && any_lane[p]
                             && (req[p].addr[ADDR_W-1:1] == own_addr[p][ADDR_W-1:1]);
        // Increment decode kept apart so the wrap check samples one signal
        assign inc_now[p]  = clk_en && cnt_ctl[p].counter_sel && cnt_ctl[p].op_reset_n
                             && cnt_ctl[p].load_n && !cnt_ctl[p].count_en_n;

        // Mailbox flag: direct register, no pipeline, set wins over clear
        always_ff @(posedge sys_clk or negedge global_async_reset_n) begin
            if (!global_async_reset_n) begin
                flag_n[p] <= dpmf_pkg::FLAG_IDLE;
            end else if (!rst_n) begin
                flag_n[p] <= dpmf_pkg::FLAG_IDLE;
            end else if (clk_en) begin
                if (wr_mbox[p]) begin
                    flag_n[p] <= 1'b0;
                end else if (rd_own[p]) begin
                    flag_n[p] <= dpmf_pkg::FLAG_IDLE;
                end
                // Otherwise hold, however long
            end
        end

        // Mailbox word storage, each lane gated by its own select
        for (genvar b = 0; b < LANES; b++) begin : g_lane
            always_ff @(posedge sys_clk or negedge global_async_reset_n) begin
                if (!global_async_reset_n) begin
                    mbox_word[p][b*LANE_W +: LANE_W] <= '0;
                end else if (!rst_n) begin
                    mbox_word[p][b*LANE_W +: LANE_W] <= '0;
                end else if (clk_en) begin
                    // Same-word writes from both ports at once are undefined; left wins
                    if (sel[0] && !req[0].rnw && !req[0].byte_lane_select_n[b]
                        && req[0].addr == own_addr[p]) begin
                        mbox_word[p][b*LANE_W +: LANE_W] <=
                            req[0].wdata[b*LANE_W +: LANE_W];
                    end else if (sel[1] && !req[1].rnw && !req[1].byte_lane_select_n[b]
                        && req[1].addr == own_addr[p]) begin
                        mbox_word[p][b*LANE_W +: LANE_W] <=
                            req[1].wdata[b*LANE_W +: LANE_W];
                    end
                end
            end
        end

        // Read data register; disabled lanes read as zero
        always_ff @(posedge sys_clk or negedge global_async_reset_n) begin
            if (!global_async_reset_n) begin
                rdata[p]  <= dpmf_pkg::DATA_RESET_VAL;
                rvalid[p] <= 1'b0;
            end else if (!rst_n) begin
                rdata[p]  <= dpmf_pkg::DATA_RESET_VAL;
                rvalid[p] <= 1'b0;
            end else if (clk_en) begin
                rvalid[p] <= rd_any[p];
                if (rd_any[p]) begin
                    for (int b = 0; b < LANES; b++) begin
                        rdata[p][b*LANE_W +: LANE_W] <= req[p].byte_lane_select_n[b]
                            ? '0
                            : mbox_word[req[p].addr[0]][b*LANE_W +: LANE_W];
                    end
                end
            end
        end

        // Burst counter, mask and wrap flag
        dpmf_burst_counter #(
            .ADDR_W (ADDR_W)
        ) u_counter (
            .sys_clk              (sys_clk),
            .rst_n                (rst_n),
            .global_async_reset_n (global_async_reset_n),
            .clk_en               (clk_en),
            .ctl                  (cnt_ctl[p]),
            .addr                 (req[p].addr),
            .count                (count[p]),
            .mask                 (mask[p]),
            .counter_wrap_flag_n  (wrap_n[p])
        );

        // Owner flag falls at the edge of a qualifying opposite write
        AST_FLAG_SET: assert property (@(posedge sys_clk)
            disable iff (!global_async_reset_n || !rst_n)
            (clk_en && wr_mbox[p]) |=> !flag_n[p])
            else $error("mailbox flag not set by opposite write");

        // Owner read clears unless a set arrives in the same edge
        AST_FLAG_CLEAR: assert property (@(posedge sys_clk)
            disable iff (!global_async_reset_n || !rst_n)
            (clk_en && rd_own[p] && !wr_mbox[p]) |=> flag_n[p])
            else $error("mailbox flag not cleared by owner read");

        // No lane active means no change
        AST_NO_LANE: assert property (@(posedge sys_clk)
            disable iff (!global_async_reset_n || !rst_n)
            (!any_lane[0] && !any_lane[1]) |=> $stable(flag_n[p]))
            else $error("flag moved with no byte lane active");

        // Flag falls only after a qualified opposite write
        AST_FLAG_CAUSE: assert property (@(posedge sys_clk)
            disable iff (!global_async_reset_n || !rst_n)
            $fell(flag_n[p]) |-> ($past(wr_mbox[p]) && $past(clk_en)))
            else $error("flag fell without an opposite mailbox write");

        // Flag stays low until an owner read; a synchronous reset also raises it
        AST_FLAG_HOLD: assert property (@(posedge sys_clk)
            disable iff (!global_async_reset_n || !rst_n)
            $rose(flag_n[p]) |-> (!$past(rst_n) || ($past(rd_own[p]) && $past(clk_en))))
            else $error("flag released without owner read");

        // Own-mailbox write never reaches the writer's flag
        AST_OWN_WRITE: assert property (@(posedge sys_clk)
            disable iff (!global_async_reset_n || !rst_n)
            (sel[p] && !req[p].rnw && req[p].addr == own_addr[p] && !wr_mbox[p]
             && flag_n[p]) |=> flag_n[p])
            else $error("own mailbox write set own flag");

        // Wrap flag falls only on an increment
        AST_WRAP_CAUSE: assert property (@(posedge sys_clk)
            disable iff (!global_async_reset_n || !rst_n)
            $fell(wrap_n[p]) |-> $past(inc_now[p]))
            else $error("wrap flag fell without increment");

        // Synchronous reset gives idle flags, zero count, full mask
        AST_RESET_STATE: assert property (@(posedge sys_clk)
            disable iff (!global_async_reset_n)
            !rst_n |=> (flag_n[p] && wrap_n[p] && count[p] == dpmf_pkg::CNT_RESET_VAL
                        && mask[p] == dpmf_pkg::MASK_RESET_VAL))
            else $error("reset state wrong");

        // No taken set or clear, or a frozen clock: flag holds
        AST_FLAG_KEEP: assert property (@(posedge sys_clk)
            disable iff (!global_async_reset_n || !rst_n)
            !(clk_en && (wr_mbox[p] || rd_own[p])) |=> $stable(flag_n[p]))
            else $error("mailbox flag moved with no set or clear");

        // Read pulse follows each gated mailbox read by one edge
        AST_RVALID: assert property (@(posedge sys_clk)
            disable iff (!global_async_reset_n || !rst_n)
            clk_en |=> (rvalid[p] == $past(rd_any[p])))
            else $error("read valid pulse misplaced");

        // Lane 0 left off during a read returns zero
        AST_LANE_ZERO: assert property (@(posedge sys_clk)
            disable iff (!global_async_reset_n || !rst_n)
            (clk_en && rd_any[p] && req[p].byte_lane_select_n[0])
            |=> (rdata[p][LANE_W-1:0] == '0))
            else $error("disabled lane did not read as zero");
    end

    // Drive the outputs from the registered arrays
    assign left_mailbox_flag_n       = flag_n[dpmf_pkg::PORT_LEFT];
    assign right_mailbox_flag_n      = flag_n[dpmf_pkg::PORT_RIGHT];
    assign left_counter_wrap_flag_n  = wrap_n[dpmf_pkg::PORT_LEFT];
    assign right_counter_wrap_flag_n = wrap_n[dpmf_pkg::PORT_RIGHT];
    assign left_rdata                = rdata[dpmf_pkg::PORT_LEFT];
    assign right_rdata               = rdata[dpmf_pkg::PORT_RIGHT];
    assign left_rvalid               = rvalid[dpmf_pkg::PORT_LEFT];
    assign right_rvalid              = rvalid[dpmf_pkg::PORT_RIGHT];
    assign left_count                = count[dpmf_pkg::PORT_LEFT];
    assign right_count               = count[dpmf_pkg::PORT_RIGHT];
    assign left_mask                 = mask[dpmf_pkg::PORT_LEFT];
    assign right_mask                = mask[dpmf_pkg::PORT_RIGHT];

endmodule : dpmf_mailbox_top

// ==== dpmf_host_model.sv ====
// Host processor model for one port of the mailbox block.
// Assumes its tasks are called at the falling clock edge; one request per call.
`timescale 1ns/1ps
module dpmf_host_model (
    // Clock
    input  wire logic            sys_clk,
    // Port request toward the block
    output dpmf_pkg::dpmf_port_s req
);

    // Idle bus: deselected, and address and data flip so stale values never look valid
    task automatic release_bus;
        req.chip_sel_low       = 1'b1;
        req.chip_sel_high      = 1'b0;
        req.rnw                = 1'b1;
        req.byte_lane_select_n = 4'hF;
        req.addr               = ~req.addr;
        req.wdata              = ~req.wdata;
    endtask : release_bus

    // One selected access, held over exactly one rising edge
    task automatic access(input logic rnw_in, input logic [15:0] a,
                          input logic [3:0] lanes, input logic [35:0] d);
        // Idle edge first, so back-to-back calls never retoggle a select at once
        @(negedge sys_clk);
        req.chip_sel_low       = 1'b0;
        req.chip_sel_high      = 1'b1;
        req.rnw                = rnw_in; // Low write, high read
        req.byte_lane_select_n = lanes;  // Active low lane gates
        req.addr               = a;
        req.wdata              = d;
        @(posedge sys_clk);
        @(negedge sys_clk);
        release_bus();
    endtask : access

    // Address only, deselected; counter loads ignore chip selects
    task automatic present_addr(input logic [15:0] a);
        @(negedge sys_clk);
        req.addr = a;
    endtask : present_addr

    // Known idle values at time zero
    initial begin
        req = '{chip_sel_low: 1'b1, chip_sel_high: 1'b0, rnw: 1'b1,
                byte_lane_select_n: 4'hF, addr: 16'h0000, wdata: 36'h000000000};
    end

endmodule : dpmf_host_model

// ==== dual_port_mailbox_flags_bench.sv ====
// Self-checking bench for the two-port mailbox flag block.
// Assumes two host models drive the ports; inputs change at the falling edge.
`timescale 1ns/1ps
module dual_port_mailbox_flags_bench;

    // Clock, resets, enable
    logic                    sys_clk;
    logic                    rst_n;
    logic                    global_async_reset_n;
    logic                    clk_en;
    // Port requests and counter controls
    dpmf_pkg::dpmf_port_s    left_req;
    dpmf_pkg::dpmf_port_s    right_req;
    dpmf_pkg::dpmf_cnt_ctl_s left_cnt_ctl;
    dpmf_pkg::dpmf_cnt_ctl_s right_cnt_ctl;
    // Outputs
    logic [35:0]             left_rdata;
    logic [35:0]             right_rdata;
    logic                    left_rvalid;
    logic                    right_rvalid;
    logic                    left_mailbox_flag_n;
    logic                    right_mailbox_flag_n;
    logic                    left_counter_wrap_flag_n;
    logic                    right_counter_wrap_flag_n;
    logic [15:0]             left_count;
    logic [15:0]             right_count;
    logic [15:0]             left_mask;
    logic [15:0]             right_mask;
    // Bookkeeping
    int                      n_errors;
    int                      check_count;

    // Counter control codes: sel, op_reset_n, load_n, count_en_n
    localparam dpmf_pkg::dpmf_cnt_ctl_s CTL_HOLD  = 4'hF;
    localparam dpmf_pkg::dpmf_cnt_ctl_s CTL_LOAD  = 4'hC;
    localparam dpmf_pkg::dpmf_cnt_ctl_s CTL_INC   = 4'hE;
    localparam dpmf_pkg::dpmf_cnt_ctl_s CTL_MLOAD = 4'h4;
    localparam logic [35:0]             DATA_A    = 36'h123456789;
    localparam logic [35:0]             DATA_B    = 36'hABCDE0F1A;

    // Block under test
    dpmf_mailbox_top dut_u (
        .sys_clk(sys_clk), .rst_n(rst_n), .global_async_reset_n(global_async_reset_n),
        .clk_en(clk_en), .left_req(left_req), .right_req(right_req),
        .left_cnt_ctl(left_cnt_ctl), .right_cnt_ctl(right_cnt_ctl),
        .left_rdata(left_rdata), .right_rdata(right_rdata),
        .left_rvalid(left_rvalid), .right_rvalid(right_rvalid),
        .left_mailbox_flag_n(left_mailbox_flag_n),
        .right_mailbox_flag_n(right_mailbox_flag_n),
        .left_counter_wrap_flag_n(left_counter_wrap_flag_n),
        .right_counter_wrap_flag_n(right_counter_wrap_flag_n),
        .left_count(left_count), .right_count(right_count),
        .left_mask(left_mask), .right_mask(right_mask)
    );

    // One host per port
    dpmf_host_model left_h (.sys_clk(sys_clk), .req(left_req));
    dpmf_host_model right_h (.sys_clk(sys_clk), .req(right_req));

    // 200 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // Compare and count; case inequality so unknowns never match
    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // Verdict and end of run
    task automatic complete_run;
        $display("checks=%0d errors=%0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : complete_run

    // All four flags, left count and right mask at their reset values
    task automatic t_reset_values;
        check(left_mailbox_flag_n, 1'b1);
        check(right_mailbox_flag_n, 1'b1);
        check(left_counter_wrap_flag_n, 1'b1);
        check(right_counter_wrap_flag_n, 1'b1);
        check(left_count, 16'h0000);
        check(right_mask, 16'hFFFF);
    endtask : t_reset_values

    // Set by left write, hold, foreign read, owner clear
    task automatic t_set_clear;
        left_h.access(1'b0, dpmf_pkg::MBOX_RIGHT_ADDR, 4'h0, DATA_A);
        check(right_mailbox_flag_n, 1'b0);
        check(left_mailbox_flag_n, 1'b1);
        repeat (6) @(negedge sys_clk);
        check(right_mailbox_flag_n, 1'b0);
        left_h.access(1'b1, dpmf_pkg::MBOX_RIGHT_ADDR, 4'h0, ~DATA_A);
        check(right_mailbox_flag_n, 1'b0);
        check(left_rdata, DATA_A);
        right_h.access(1'b1, dpmf_pkg::MBOX_RIGHT_ADDR, 4'hE, ~DATA_A);
        check(right_mailbox_flag_n, 1'b1);
        check(right_rvalid, 1'b1);
        check(right_rdata, DATA_A & 36'h1FF);
        @(negedge sys_clk);
        check(right_rvalid, 1'b0);
    endtask : t_set_clear

    // Lane-less writes and reads change nothing; a single lane suffices
    task automatic t_lanes;
        clk_en = 1'b0;
        left_h.access(1'b0, dpmf_pkg::MBOX_RIGHT_ADDR, 4'h0, DATA_B);
        clk_en = 1'b1;
        check(right_mailbox_flag_n, 1'b1);
        left_h.access(1'b0, dpmf_pkg::MBOX_RIGHT_ADDR, 4'hF, DATA_B);
        check(right_mailbox_flag_n, 1'b1);
        left_h.access(1'b0, dpmf_pkg::MBOX_RIGHT_ADDR, 4'h7, DATA_B);
        check(right_mailbox_flag_n, 1'b0);
        right_h.access(1'b1, dpmf_pkg::MBOX_RIGHT_ADDR, 4'hF, ~DATA_B);
        check(right_mailbox_flag_n, 1'b0);
        right_h.access(1'b1, dpmf_pkg::MBOX_RIGHT_ADDR, 4'h7, ~DATA_B);
        check(right_mailbox_flag_n, 1'b1);
    endtask : t_lanes

    // Own-word writes are silent; left mailbox sits one below the top
    task automatic t_own_and_left;
        right_h.access(1'b0, dpmf_pkg::MBOX_RIGHT_ADDR, 4'h0, DATA_B);
        left_h.access(1'b0, dpmf_pkg::MBOX_LEFT_ADDR, 4'h0, DATA_A);
        check({left_mailbox_flag_n, right_mailbox_flag_n}, 2'b11);
        right_h.access(1'b0, dpmf_pkg::MBOX_LEFT_ADDR, 4'h0, DATA_B);
        check(left_mailbox_flag_n, 1'b0);
        check(right_mailbox_flag_n, 1'b1);
        left_h.access(1'b1, 16'hFFFE, 4'h0, ~DATA_B);
        check(left_mailbox_flag_n, 1'b1);
        check(left_rdata, DATA_B);
    endtask : t_own_and_left

    // Load near the top, increment into all ones
    task automatic t_counter_wrap;
        left_h.present_addr(16'hFFFD);
        left_cnt_ctl = CTL_LOAD;
        @(negedge sys_clk);
        left_cnt_ctl = CTL_INC;
        @(negedge sys_clk);
        check(left_counter_wrap_flag_n, 1'b1);
        @(negedge sys_clk);
        left_cnt_ctl = CTL_HOLD;
        check(left_count, 16'hFFFF);
        check(left_counter_wrap_flag_n, 1'b0);
    endtask : t_counter_wrap

    // Global reset between edges clears both ports at once
    task automatic t_global_reset;
        right_h.present_addr(16'h000F);
        right_cnt_ctl = CTL_MLOAD;
        @(negedge sys_clk);
        right_cnt_ctl = CTL_HOLD;
        check(right_mask, 16'h000F);
        left_h.access(1'b0, dpmf_pkg::MBOX_RIGHT_ADDR, 4'h0, DATA_A);
        right_h.access(1'b0, dpmf_pkg::MBOX_LEFT_ADDR, 4'h0, DATA_A);
        global_async_reset_n = 1'b0;
        #1;
        // No clock edge yet: everything must already be clear
        check({left_mailbox_flag_n, right_mailbox_flag_n}, 2'b11);
        check({left_counter_wrap_flag_n, right_counter_wrap_flag_n}, 2'b11);
        check({left_count, right_count}, 32'h00000000);
        check({left_mask, right_mask}, 32'hFFFFFFFF);
        @(negedge sys_clk);
        global_async_reset_n = 1'b1;
        // Synchronous reset mid-run also idles a set flag
        left_h.access(1'b0, dpmf_pkg::MBOX_RIGHT_ADDR, 4'h0, DATA_A);
        rst_n = 1'b0;
        @(negedge sys_clk);
        rst_n = 1'b1;
        check(right_mailbox_flag_n, 1'b1);
    endtask : t_global_reset

    // Watchdog sized well above the roughly 50 cycles of traffic
    initial begin
        #(2000 * 5);
        n_errors++;
        complete_run();
    end

    // Main sequence
    initial begin
        n_errors             = 0;
        check_count          = 0;
        clk_en               = 1'b1;
        left_cnt_ctl         = CTL_HOLD;
        right_cnt_ctl        = CTL_HOLD;
        rst_n                = 1'b0;
        global_async_reset_n = 1'b0; // Power-up reset before any access
        repeat (4) @(posedge sys_clk);
        @(negedge sys_clk);
        rst_n                = 1'b1;
        global_async_reset_n = 1'b1;
        t_reset_values();
        t_set_clear();
        t_lanes();
        t_own_and_left();
        t_counter_wrap();
        t_global_reset();
        complete_run();
    end

endmodule : dual_port_mailbox_flags_bench
